// file: cnt_control.sv
/*
  16-bit counter with its control register, reached over APB.
  assumes pins sampled on clk; comparator and gate pins are levels.
*/
`timescale 1ns/1ps
`include "cnt_defines.svh"

module cnt_control
  import cnt_pkg::*;
#(
  parameter int INSTR_DIV = `CNT_INSTR_DIV  // system clocks per instruction
)(
  input  wire logic        clk,                  // system clock, 250 MHz
  input  wire logic        reset,                // async, active high
  input  wire logic        psel,                 // apb select
  input  wire logic        penable,              // apb access phase
  input  wire logic        pwrite,               // apb direction
  input  wire logic [11:0] paddr,                // apb byte address
  input  wire logic [31:0] pwdata,               // apb write data
  output      logic [31:0] prdata,               // apb read data
  output      logic        pready,               // apb ready
  output      logic        pslverr,              // apb error
  input  wire logic        external_clock_pin,   // external count input
  input  wire logic        lowpower_osc_in,      // low-power oscillator output
  input  wire logic        internal_osc_active,  // internal osc, no clock out
  input  wire logic        gate_pin,             // gate input pin
  input  wire logic        comparator_output,    // comparator gate source
  input  wire logic        sleep_mode,           // device asleep
  output      logic        lowpower_osc_on,      // enables low-power oscillator
  output      logic [15:0] count                 // counter value
);
  // refuse divider values that the 8-bit instruction counter cannot serve
  if (INSTR_DIV < 1 || INSTR_DIV > 256) begin : g_bad_div
    $error("INSTR_DIV out of range");
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  cnt_psc_if  psc ();              // prescaler link
  cnt_ctrl_t  ctrl;                // control register
  logic       gate_source_select;  // 1 comparator, 0 pin
  logic [7:0] instr_cnt;           // instruction clock divider
  logic       instr_tick;          // one per instruction cycle
  logic       ext_meta;            // synchroniser stage one
  logic       ext_sync;            // synchroniser stage two
  logic       ext_sync_prev;       // previous synchronised level
  logic       ext_raw_prev;        // previous raw level, bypass path
  logic       ext_src;             // chosen external source
  logic       ext_edge;            // rising edge of external source
  logic       async_mode;          // external and unsynchronised
  logic       gate_src;            // selected gate level
  logic       gate_open;           // gate allows counting
  logic       base_tick;           // source edge before gating
  logic       count_enable;        // run, gate and sleep state all allow
  logic       setup;               // apb setup phase
  logic       wr_access;           // apb write taken
  logic       wr_low;              // write to low byte
  logic       wr_high;             // write to high byte
  logic       cnt_write;           // either count byte written

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `CNT_OFF_CONTROL) || (a == `CNT_OFF_COUNT_LOW) ||
             (a == `CNT_OFF_COUNT_HIGH) || (a == `CNT_OFF_GATE_SEL) ||
             (a == `CNT_OFF_STATUS);
  endfunction

  assign setup     = psel && !penable;
  assign wr_access = psel && penable && pwrite && mapped(paddr);
  assign wr_low    = wr_access && (paddr == `CNT_OFF_COUNT_LOW);
  assign wr_high   = wr_access && (paddr == `CNT_OFF_COUNT_HIGH);
  assign cnt_write = wr_low || wr_high;
  // zero wait states: answer in the first access cycle
  assign pready    = psel && penable;
  assign pslverr   = psel && penable && !mapped(paddr);

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl <= cnt_ctrl_t'(`CNT_CONTROL_RESET);
    end else if (wr_access && paddr == `CNT_OFF_CONTROL) begin
      ctrl <= cnt_ctrl_t'(pwdata[7:0]);
    end
  end

  // gate source bit, outside the main control word
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gate_source_select <= `CNT_GATE_SEL_RESET;
    end else if (wr_access && paddr == `CNT_OFF_GATE_SEL) begin
      gate_source_select <= pwdata[0];
    end
  end

  // ----------------------------------------------------------------
  // read data, captured in the setup cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      unique case (paddr)
        `CNT_OFF_CONTROL:    prdata <= {24'h00_0000, ctrl};
        `CNT_OFF_COUNT_LOW:  prdata <= {24'h00_0000, count[7:0]};
        `CNT_OFF_COUNT_HIGH: prdata <= {24'h00_0000, count[15:8]};
        `CNT_OFF_GATE_SEL:   prdata <= {31'h0000_0000, gate_source_select};
        `CNT_OFF_STATUS:     prdata <= {28'h000_0000, gate_open, lowpower_osc_on,
                                        async_mode, count_enable};
        default:             prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // instruction clock: one tick every INSTR_DIV system clocks
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      instr_cnt <= 8'h00;
    end else if (instr_cnt == 8'(INSTR_DIV - 1)) begin
      instr_cnt <= 8'h00;
    end else begin
      instr_cnt <= instr_cnt + 8'h01;
    end
  end
  assign instr_tick = (instr_cnt == 8'(INSTR_DIV - 1));

  // ----------------------------------------------------------------
  // external source and edge detection
  // ----------------------------------------------------------------
  // low-power oscillator only serves with the internal oscillator running
  assign lowpower_osc_on = ctrl.lowpower_osc_enable && internal_osc_active;
  assign ext_src = lowpower_osc_on ? lowpower_osc_in : external_clock_pin;
  assign async_mode = ctrl.clock_source_select && ctrl.sync_bypass;

  // prev levels reset high so a falling edge must precede the first count
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ext_meta      <= 1'b1;
      ext_sync      <= 1'b1;
      ext_sync_prev <= 1'b1;
      ext_raw_prev  <= 1'b1;
    end else begin
      ext_meta      <= ext_src;
      ext_sync      <= ext_meta;
      ext_sync_prev <= ext_sync;
      ext_raw_prev  <= ext_src;
    end
  end

  // bypass saves two cycles of latency but risks a glitchy count
  assign ext_edge = ctrl.sync_bypass ? (ext_src && !ext_raw_prev)
                                     : (ext_sync && !ext_sync_prev);

  // ----------------------------------------------------------------
  // source select, gate and run qualification
  // ----------------------------------------------------------------
  assign base_tick = ctrl.clock_source_select ? ext_edge : instr_tick;
  assign gate_src  = gate_source_select ? comparator_output : gate_pin;
  assign gate_open = ctrl.gate_invert ? gate_src : !gate_src;
  // gate matters only while running and qualified
  assign count_enable = ctrl.counter_run &&
                        (!ctrl.gate_qualify_enable || gate_open) &&
                        (!sleep_mode || async_mode);

  assign psc.tick  = base_tick && count_enable;
  assign psc.clear = cnt_write;
  assign psc.sel   = ctrl.input_prescale_select;

  cnt_prescaler u_psc (
    .clk   (clk),
    .reset (reset),
    .p     (psc)
  );

  // ----------------------------------------------------------------
  // the count; a software write beats an increment
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count <= `CNT_COUNT_RESET;
    end else if (wr_low) begin
      count[7:0] <= pwdata[7:0];
    end else if (wr_high) begin
      count[15:8] <= pwdata[7:0];
    end else if (psc.pulse) begin
      count <= count + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_cnt_write;
    cnt_write;
  endsequence

  sequence s_quiet_pulse;
    psc.pulse && !cnt_write;
  endsequence

  chk_gate_polarity: assert property (
    @(posedge clk) disable iff (reset)
    ctrl.counter_run && ctrl.gate_qualify_enable && (ctrl.gate_invert != gate_src)
      |-> !psc.tick)
    else $error("counted while gate closed");

  chk_gate_ignored: assert property (
    @(posedge clk) disable iff (reset)
    ctrl.counter_run && !ctrl.gate_qualify_enable && !sleep_mode && base_tick
      |-> psc.tick)
    else $error("gate blocked an unqualified count");

  chk_prescale_wrap: assert property (
    @(posedge clk) disable iff (reset)
    psc.pulse |-> psc.count == ((3'h1 << psc.sel) - 3'h1))
    else $error("prescaler pulse at wrong count");

  chk_lp_osc_on: assert property (
    @(posedge clk) disable iff (reset)
    lowpower_osc_on == (ctrl[`CNT_BIT_LP_OSC] && internal_osc_active))
    else $error("low-power oscillator enable wrong");

  chk_run_stop: assert property (
    @(posedge clk) disable iff (reset)
    !ctrl.counter_run && !cnt_write |=> count == $past(count))
    else $error("count moved while stopped");

  chk_clock_select: assert property (
    @(posedge clk) disable iff (reset)
    ctrl.counter_run && !ctrl.gate_qualify_enable && !sleep_mode &&
      !ctrl.clock_source_select && instr_tick |-> psc.tick)
    else $error("instruction tick not counted");

  chk_sleep_hold: assert property (
    @(posedge clk) disable iff (reset)
    sleep_mode && !async_mode |-> !psc.tick)
    else $error("synchronous count during sleep");

  chk_psc_clear: assert property (
    @(posedge clk) disable iff (reset)
    s_cnt_write |=> psc.count == 3'h0)
    else $error("prescaler not cleared by count write");

  chk_count_step: assert property (
    @(posedge clk) disable iff (reset)
    s_quiet_pulse |=> count == $past(count) + 16'h0001)
    else $error("count did not step by one");
endmodule

// file: cnt_defines.svh
/*
  constants of the counter control block: register offsets, field
  positions, reset values and timing counts.
  assumes inclusion by bare name; holds definitions only.
*/
`ifndef CNT_DEFINES_SVH
`define CNT_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CNT_OFF_CONTROL    12'h000
`define CNT_OFF_COUNT_LOW  12'h004
`define CNT_OFF_COUNT_HIGH 12'h008
`define CNT_OFF_GATE_SEL   12'h00c
`define CNT_OFF_STATUS     12'h010

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CNT_BIT_GATE_INVERT   7
`define CNT_BIT_GATE_QUALIFY  6
`define CNT_PSC_HI            5
`define CNT_PSC_LO            4
`define CNT_BIT_LP_OSC        3
`define CNT_BIT_SYNC_BYPASS   2
`define CNT_BIT_CLK_SELECT    1
`define CNT_BIT_RUN           0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CNT_CONTROL_RESET  8'h00
`define CNT_GATE_SEL_RESET 1'b1
`define CNT_COUNT_RESET    16'h0000

// ----------------------------------------------------------------
// timing: instruction clock is a quarter of the system clock
// ----------------------------------------------------------------
`define CNT_INSTR_DIV 4

`endif

// file: cnt_far_side.sv
/*
  far-side model: external count pin, low-power oscillator, gate pin
  and comparator output.
  assumes the bench sets levels and enables just after clk edges.
*/
`timescale 1ns/1ps
module cnt_far_side (
  input  wire logic       clk,                 // system clock
  input  wire logic       ext_run,             // pulses on the count pin
  input  wire logic       lp_run,              // oscillator running
  input  wire logic [7:0] ext_half,            // half period, clk cycles
  input  wire logic       gate_level,          // wanted gate pin level
  input  wire logic       cmp_level,           // wanted comparator level
  output      logic       external_clock_pin,  // count pulses
  output      logic       lowpower_osc_in,     // oscillator waveform
  output      logic       gate_pin,            // gate pin
  output      logic       comparator_output    // comparator gate source
);
  logic [7:0] phase_cnt;  // cycles into the half period
  logic       train;      // free square wave behind both sources
  initial begin
    phase_cnt = 8'h00;
    train = 1'b0;
  end
  // ----------------------------------------------------------------
  // square wave; sources stand low when off, so the first edge
  // after switching on can be a rising one
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (phase_cnt + 8'h01 >= ext_half) begin
      phase_cnt <= 8'h00;
      train <= ~train;
    end else begin
      phase_cnt <= phase_cnt + 8'h01;
    end
  end
  assign external_clock_pin = ext_run & train;
  assign lowpower_osc_in    = lp_run & train;
  assign gate_pin           = gate_level;
  assign comparator_output  = cmp_level;
endmodule

// file: cnt_pkg.sv
/*
  types of the counter control block.
  assumes cnt_defines.svh for the numeric constants.
*/
package cnt_pkg;

  // prescale ratio encodings
  typedef enum logic [1:0] {
    CNT_PSC_DIV1 = 2'b00,  // no division
    CNT_PSC_DIV2 = 2'b01,  // divide by 2
    CNT_PSC_DIV4 = 2'b10,  // divide by 4
    CNT_PSC_DIV8 = 2'b11   // divide by 8
  } cnt_psc_t;

  // view of the control register
  typedef struct packed {
    logic     gate_invert;          // gate polarity
    logic     gate_qualify_enable;  // gate steers counting
    cnt_psc_t input_prescale_select;// prescale ratio
    logic     lowpower_osc_enable;  // low-power oscillator on
    logic     sync_bypass;          // skip synchroniser
    logic     clock_source_select;  // 0 instr clock, 1 pin or low-power osc
    logic     counter_run;          // run/stop
  } cnt_ctrl_t;

endpackage

// file: cnt_prescaler.sv
/*
  hidden prescale counter: divides qualified ticks by 1, 2, 4 or 8.
  assumes tick and clear synchronous to clk.
*/
`timescale 1ns/1ps
module cnt_prescaler
  import cnt_pkg::*;
(
  input wire logic clk,   // system clock
  input wire logic reset, // async, active high
  cnt_psc_if.psc   p      // control side
);
  logic [2:0] limit;  // last count before a pulse

  // ----------------------------------------------------------------
  // ratio decode
  // ----------------------------------------------------------------
  always_comb begin
    unique case (p.sel)
      CNT_PSC_DIV1: limit = 3'h0;
      CNT_PSC_DIV2: limit = 3'h1;
      CNT_PSC_DIV4: limit = 3'h3;
      CNT_PSC_DIV8: limit = 3'h7;
    endcase
  end

  // pulse on the tick that completes a ratio
  assign p.pulse = p.tick && !p.clear && (p.count == limit);

  // ----------------------------------------------------------------
  // hidden count; a clear beats a tick
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      p.count <= 3'h0;
    end else if (p.clear) begin
      p.count <= 3'h0;
    end else if (p.pulse) begin
      p.count <= 3'h0;
    end else if (p.tick) begin
      p.count <= p.count + 3'h1;
    end
  end
endmodule

// file: cnt_psc_if.sv
/*
  carrier between the control block and its prescaler.
  assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface cnt_psc_if;
  import cnt_pkg::*;
  logic       tick;   // qualified input edge
  logic       clear;  // clear hidden count
  cnt_psc_t   sel;    // ratio select
  logic       pulse;  // prescaler output pulse
  logic [2:0] count;  // hidden count, for checks only

  modport ctrl (output tick, output clear, output sel, input pulse, input count);
  modport psc  (input tick, input clear, input sel, output pulse, output count);
endinterface

// file: counter16_control_test.sv
/*
  self-checking bench of the counter control block.
  assumes the package, header, interface and design are compiled first.
*/
`timescale 1ns/1ps
`include "cnt_defines.svh"
module counter16_control_test;
  import cnt_pkg::*;
  localparam int IDIV = 4;  // system clocks per instruction tick
  logic clk, reset, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic internal_osc_active, sleep_mode, lowpower_osc_on;
  logic external_clock_pin, lowpower_osc_in, gate_pin, comparator_output;
  logic ext_run, lp_run, gate_level, cmp_level;
  logic [7:0] ext_half;
  logic [15:0] count, d;
  int mismatches, n_checks, cycles;

  cnt_control #(.INSTR_DIV(IDIV)) DUT (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_clock_pin(external_clock_pin), .lowpower_osc_in(lowpower_osc_in),
    .internal_osc_active(internal_osc_active), .gate_pin(gate_pin),
    .comparator_output(comparator_output), .sleep_mode(sleep_mode),
    .lowpower_osc_on(lowpower_osc_on), .count(count));
  cnt_far_side far (.clk(clk), .ext_run(ext_run), .lp_run(lp_run),
    .ext_half(ext_half), .gate_level(gate_level), .cmp_level(cmp_level),
    .external_clock_pin(external_clock_pin), .lowpower_osc_in(lowpower_osc_in),
    .gate_pin(gate_pin), .comparator_output(comparator_output));

  always #2 clk = ~clk;
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(logic w, logic [11:0] a, logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // count advance over n cycles, after a settling gap
  task automatic measure(int n);
    logic [15:0] a;
    repeat (12) @(negedge clk);
    a = count;
    repeat (n) @(negedge clk);
    d = count - a;
    @(posedge clk);  // hand back on a rising edge so callers drive there
  endtask
  task automatic ctrl(logic [7:0] c);
    apb(1'b1, `CNT_OFF_CONTROL, {24'h0, c});
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_regs();
    apb(1'b0, `CNT_OFF_CONTROL, 32'h0);
    check("control reset", rd, 32'h0);
    apb(1'b0, `CNT_OFF_GATE_SEL, 32'h0);
    check("gate select reset", rd, 32'h1);
    check("count reset", {16'h0, count}, 32'h0);
    ext_run <= 1'b1;
    ctrl(8'hfe);  // every bit but run: must not count
    apb(1'b0, `CNT_OFF_CONTROL, 32'h0);
    check("control rw", rd, 32'hfe);
    measure(48);
    check("stopped count", {16'h0, d}, 32'h0);
    ext_run <= 1'b0;
    apb(1'b1, 12'h020, 32'hff);
    check("unmapped write err", {31'h0, err}, 32'h1);
    apb(1'b0, 12'h020, 32'h0);
    check("unmapped read data", rd, 32'h0);
    $display("test reset_regs done");
  endtask
  task automatic t_prescale();
    for (int k = 0; k < 4; k++) begin
      ctrl({2'b00, 2'(k), 4'b0001});
      measure(IDIV * (1 << k) * 8);
      check("prescaled count", {16'h0, d}, 32'd8);
    end
    $display("test prescale done");
  endtask
  task automatic t_gate();
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, `CNT_OFF_GATE_SEL, 32'(s));
      for (int v = 0; v < 4; v++) begin
        ctrl({v[1], 7'b1000001});  // invert, qualify, div1, run
        gate_level <= (s == 0) ? v[0] : ~v[0];
        cmp_level <= (s == 1) ? v[0] : ~v[0];
        measure(IDIV * 8);
        check("gated count", {16'h0, d}, (v[0] == v[1]) ? 32'd8 : 32'd0);
      end
    end
    cmp_level <= 1'b0;  // gate closed for active-high, qualify off
    ctrl(8'h81);
    measure(IDIV * 8);
    check("ungated count", {16'h0, d}, 32'd8);
    $display("test gate done");
  endtask
  task automatic t_external();
    ext_run <= 1'b1;
    ctrl(8'h03);
    measure(48);
    check("pin count", {16'h0, d}, 32'd8);
    sleep_mode <= 1'b1;  // synchronised counting halts asleep
    measure(48);
    check("sync asleep", {16'h0, d}, 32'd0);
    ctrl(8'h07);
    measure(48);
    check("async asleep", {16'h0, d}, 32'd8);
    apb(1'b0, `CNT_OFF_STATUS, 32'h0);
    check("status async", rd, 32'hb);
    sleep_mode <= 1'b0;
    for (int v = 0; v < 4; v++) begin
      internal_osc_active <= v[0];
      ctrl({4'h0, v[1], 3'b011});
      @(negedge clk);
      check("lp osc on", {31'h0, lowpower_osc_on}, 32'(v[0] & v[1]));
      @(posedge clk);
    end
    measure(48);  // idle oscillator replaces the running pin source
    check("lp source idle", {16'h0, d}, 32'd0);
    lp_run <= 1'b1;
    measure(48);  // running oscillator now drives the count
    check("lp source runs", {16'h0, d}, 32'd8);
    lp_run <= 1'b0;
    ext_run <= 1'b0;
    internal_osc_active <= 1'b0;
    $display("test external done");
  endtask
  task automatic t_count_write();
    ctrl(8'h30);
    apb(1'b1, `CNT_OFF_COUNT_HIGH, 32'h12);
    apb(1'b1, `CNT_OFF_COUNT_LOW, 32'h5a);
    @(negedge clk);
    check("byte writes", {16'h0, count}, 32'h125a);
    apb(1'b0, `CNT_OFF_COUNT_LOW, 32'h0);
    check("low byte read", rd, 32'h5a);
    apb(1'b0, `CNT_OFF_COUNT_HIGH, 32'h0);
    check("high byte read", rd, 32'h12);
    ctrl(8'h31);
    repeat (50) @(posedge clk);  // leave the prescaler mid-count
    apb(1'b1, `CNT_OFF_COUNT_LOW, 32'h00);
    @(negedge clk);
    check("low write", {16'h0, count}, 32'h1200);
    repeat (24) @(negedge clk);
    check("prescaler cleared", {16'h0, count}, 32'h1200);
    repeat (16) @(negedge clk);
    check("first increment", {16'h0, count}, 32'h1201);
    $display("test count_write done");
  endtask
  // ----------------------------------------------------------------
  // verdict, timeout and main sequence
  // ----------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    {clk, psel, penable, pwrite, paddr, pwdata} = '0;
    {internal_osc_active, sleep_mode, ext_run, lp_run, gate_level} = '0;
    cmp_level = 1'b0;
    ext_half = 8'h03;
    {mismatches, n_checks, cycles} = '0;
    reset = 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    t_reset_regs();
    t_prescale();
    t_gate();
    t_external();
    t_count_write();
    results();
  end
endmodule
